// ### baud_timer.sv
// Eight-bit auto-reload baud timer giving a one-cycle overflow pulse.
// Assumes tick_i is a one-cycle timer clock enable synchronous to mclk_i.
`timescale 1ns/1ps
module baud_timer (
  // Clock and reset.
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // Timer controls.
  input  wire logic       tick_i,
  input  wire logic [7:0] reload_i,
  input  wire logic       restart_i,
  // Overflow pulse.
  output logic            ovf_o
);

  logic [7:0] cnt_reg;

  // Counts up from the reload value and reloads on overflow or restart.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 8'h00;
      ovf_o   <= 1'b0;
    end else if (restart_i) begin
      cnt_reg <= reload_i;
      ovf_o   <= 1'b0;
    end else if (tick_i && cnt_reg == uart_mp_pkg::TIMER_TOP) begin
      cnt_reg <= reload_i;
      ovf_o   <= 1'b1;
    end else begin
      cnt_reg <= tick_i ? cnt_reg + 8'h01 : cnt_reg;
      ovf_o   <= 1'b0;
    end
  end

endmodule // baud_timer

// ### serial_partner.sv
// Remote serial processor model that faces the port over its two serial lines.
// Assumes one bit lasts bit_len clock cycles and the line idles high between frames.
`timescale 1ns/1ps
module serial_partner (
  // Clock.
  input  wire logic mclk_i,
  // Serial lines.
  input  wire logic from_port_i,
  output logic      to_port_o
);
  // The line rests high outside frames.
  initial to_port_o = 1'b1;

  // Sends start, eight data bits LSB first, an optional ninth bit, then stop.
  task automatic send_frame(input int bit_len, input logic [7:0] data, input logic nine,
                            input logic ninth, input logic stop);
    logic [10:0] bits;
    bits = nine ? {stop, ninth, data, 1'b0} : {1'b1, stop, data, 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      @(posedge mclk_i);
      #1 to_port_o = bits[i];
      repeat (bit_len - 1) @(posedge mclk_i);
    end
    @(posedge mclk_i);
    #1 to_port_o = 1'b1;
    repeat (2 * bit_len) @(posedge mclk_i);
  endtask

  // Captures one frame; the first data bit must be high so the start bit end shows.
  task automatic get_frame(input int bit_len, input logic nine, output logic [8:0] got,
                           output logic stop, output logic ok);
    int n;
    ok = 1'b0;
    got = 9'h000;
    stop = 1'b0;
    n = 0;
    while (from_port_i !== 1'b0 && n < 4000) begin
      @(posedge mclk_i);
      n++;
    end
    while (from_port_i !== 1'b1 && n < 4000) begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 4000) return;
    repeat (bit_len / 2) @(posedge mclk_i);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      if (i > 0) repeat (bit_len) @(posedge mclk_i);
      got[i] = from_port_i;
    end
    repeat (bit_len) @(posedge mclk_i);
    stop = from_port_i;
    ok = 1'b1;
  endtask
endmodule  // serial_partner

// ### testbench.sv
// Self-checking bench for the serial port: registers, both frame formats, filter, buffer.
// Assumes the timer counts every clock, so one bit lasts two overflows of four ticks.
`timescale 1ns/1ps
module testbench;
  localparam int BIT_LEN = 8;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        irq_en = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata;
  logic        irq;
  logic        buf_rdy;
  logic        rx_line;
  logic        tx_line;
  logic [7:0]  rd_val;
  logic [7:0]  d;
  logic [7:0]  last_rx = 8'h00;
  logic [8:0]  got;
  logic        stop_seen;
  logic        ok;
  logic        acc;
  logic [31:0] seed = 32'h98f3_d600;
  int          miscompares = 0;
  int          total_checks = 0;

  // Clock of 4 ns.
  always #2 mclk = ~mclk;

  uart_mp_serial_port dut (.mclk_i(mclk), .rst_i(rst), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .baud_tick_i(1'b1),
    .baud_reload_value_i(8'hFC), .serial_int_enable_i(irq_en), .serial_irq_o(irq),
    .tx_buf_ready_o(buf_rdy), .serial_in_pin_i(rx_line), .serial_out_pin_o(tx_line));
  serial_partner far_node (.mclk_i(mclk), .from_port_i(tx_line), .to_port_o(rx_line));

  // Next value of the stimulus shift register.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction

  // A byte is kept unless the filter is on and the checked bit is low.
  function automatic logic accept(input logic mce, input logic b);
    return !mce || b;
  endfunction

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    #1 addr = a;
    wdata = v;
    wr = 1'b1;
    @(posedge mclk);
    #1 wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a);
    @(posedge mclk);
    #1 addr = a;
    rd = 1'b1;
    @(posedge mclk);
    #1 rd = 1'b0;
    rd_val = rdata;
  endtask

  // Takes one frame from the line and compares it; a lost frame ends the run.
  task automatic expect_frame(input logic nine, input logic [8:0] exp);
    far_node.get_frame(BIT_LEN, nine, got, stop_seen, ok);
    check({8'h00, ok}, 9'h001);
    if (!ok) end_sim();
    check(got, exp);
    check({8'h00, stop_seen}, 9'h001);
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    #1 rst = 1'b0;
    // Reset values, then bit six ignoring a write of zero.
    reg_rd(uart_mp_pkg::CTRL_ADDR);
    check({1'b0, rd_val}, 9'h040);
    reg_rd(uart_mp_pkg::DATA_ADDR);
    check({1'b0, rd_val}, 9'h000);
    reg_wr(uart_mp_pkg::CTRL_ADDR, 8'h00);
    reg_rd(uart_mp_pkg::CTRL_ADDR);
    check({1'b0, rd_val}, 9'h040);
    $display("Test registers done");
    // Transmit in eight-bit mode, then nine-bit with both ninth levels.
    for (int m = 0; m < 3; m++) begin
      seed = lfsr(seed);
      d = seed[7:0] | 8'h01;
      reg_wr(uart_mp_pkg::CTRL_ADDR, m == 0 ? 8'h00 : (m == 1 ? 8'h88 : 8'h80));
      irq_en = (m == 1);
      reg_wr(uart_mp_pkg::DATA_ADDR, d);
      expect_frame(m != 0, {m == 1, d});
      reg_rd(uart_mp_pkg::CTRL_ADDR);
      check({8'h00, rd_val[uart_mp_pkg::TI_BIT]}, 9'h001);
      check({8'h00, irq}, {8'h00, m == 1});
    end
    $display("Test transmit done");
    // Three writes back to back, then a fourth: two wait behind the shifter, the fourth is refused.
    reg_wr(uart_mp_pkg::CTRL_ADDR, 8'h00);
    // The line is watched from before the first write, so a short start bit is not missed.
    fork
      for (int i = 0; i < 3; i++) expect_frame(1'b0, {5'h03, 4'(2 * i + 1)});
      begin
        @(posedge mclk);
        #1 addr = uart_mp_pkg::DATA_ADDR;
        wr = 1'b1;
        for (int i = 0; i < 3; i++) begin
          wdata = {4'h3, 4'(2 * i + 1)};
          @(posedge mclk);
          #1;
        end
        wr = 1'b0;
        repeat (2) @(posedge mclk);
        #1 check({8'h00, buf_rdy}, 9'h000);
        wdata = 8'h77;
        wr = 1'b1;
        @(posedge mclk);
        #1 wr = 1'b0;
      end
    join
    far_node.get_frame(BIT_LEN, 1'b0, got, stop_seen, ok);
    check({8'h00, ok}, 9'h000);
    check({8'h00, buf_rdy}, 9'h001);
    $display("Test buffer done");
    // Receive in every mode, filter and checked-bit combination.
    irq_en = 1'b1;
    for (int k = 0; k < 8; k++) begin
      reg_wr(uart_mp_pkg::CTRL_ADDR, {k[2], 1'b0, k[1], 1'b1, 4'h0});
      seed = lfsr(seed);
      d = seed[15:8];
      far_node.send_frame(BIT_LEN, d, k[2], k[0], k[2] ? 1'b1 : k[0]);
      acc = accept(k[1], k[0]);
      if (acc) last_rx = d;
      reg_rd(uart_mp_pkg::CTRL_ADDR);
      check({7'h00, rd_val[2], rd_val[0]}, {7'h00, acc & k[0], acc});
      check({8'h00, irq}, {8'h00, acc});
      reg_rd(uart_mp_pkg::DATA_ADDR);
      check({1'b0, rd_val}, {1'b0, last_rx});
    end
    // Done flag still set: the next byte is dropped and the flag stays.
    far_node.send_frame(BIT_LEN, ~last_rx, 1'b1, 1'b1, 1'b1);
    reg_rd(uart_mp_pkg::DATA_ADDR);
    check({1'b0, rd_val}, {1'b0, last_rx});
    reg_rd(uart_mp_pkg::CTRL_ADDR);
    check({8'h00, rd_val[0]}, 9'h001);
    // Address byte taken with the filter on, data after it is cleared, none once set again.
    reg_wr(uart_mp_pkg::CTRL_ADDR, 8'hB0);
    far_node.send_frame(BIT_LEN, 8'h5B, 1'b1, 1'b1, 1'b1);
    reg_rd(uart_mp_pkg::DATA_ADDR);
    check({1'b0, rd_val}, 9'h05B);
    reg_wr(uart_mp_pkg::CTRL_ADDR, 8'h90);
    far_node.send_frame(BIT_LEN, 8'hA4, 1'b1, 1'b0, 1'b1);
    reg_rd(uart_mp_pkg::DATA_ADDR);
    check({1'b0, rd_val}, 9'h0A4);
    reg_wr(uart_mp_pkg::CTRL_ADDR, 8'hB0);
    far_node.send_frame(BIT_LEN, 8'h3C, 1'b1, 1'b0, 1'b1);
    reg_rd(uart_mp_pkg::CTRL_ADDR);
    check({8'h00, rd_val[0]}, 9'h000);
    // Receiver disabled: nothing is taken.
    reg_wr(uart_mp_pkg::CTRL_ADDR, 8'h00);
    far_node.send_frame(BIT_LEN, ~last_rx, 1'b0, 1'b0, 1'b1);
    reg_rd(uart_mp_pkg::CTRL_ADDR);
    check({8'h00, rd_val[0]}, 9'h000);
    check({8'h00, irq}, 9'h000);
    $display("Test receive done");
    end_sim();
  end
endmodule  // testbench

// ### two_entry_buffer.sv
// Two-entry byte buffer with valid and ready on both sides.
// Assumes the consumer holds out_ready_i as it pleases; a push while full is refused.
`timescale 1ns/1ps
module two_entry_buffer (
  // Clock and reset.
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // Fill side.
  input  wire logic       in_valid_i,
  output logic            in_ready_o,
  input  wire logic [7:0] in_data_i,
  // Drain side.
  output logic            out_valid_o,
  input  wire logic       out_ready_i,
  output logic [7:0]      out_data_o
);

  logic [7:0] mem_reg [2];
  logic       wr_ptr_reg;
  logic       rd_ptr_reg;
  logic [1:0] count_reg;
  logic       push;
  logic       pop;

  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_valid_o = count_reg != 2'h0;
  assign out_data_o  = mem_reg[rd_ptr_reg];

  // Pointers, occupancy and a registered ready that is low only when full.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
      in_ready_o <= 1'b1;
    end else begin
      wr_ptr_reg <= wr_ptr_reg ^ push;
      rd_ptr_reg <= rd_ptr_reg ^ pop;
      count_reg  <= count_reg + {1'b0, push} - {1'b0, pop};
      in_ready_o <= (count_reg + {1'b0, push} - {1'b0, pop}) != 2'h2;
    end
  end

  // Storage for the two entries.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_reg[0] <= 8'h00;
      mem_reg[1] <= 8'h00;
    end else if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

endmodule // two_entry_buffer

// ### uart_mp_pkg.sv
// Constants shared by the multiprocessor serial port: register offsets,
// control bit positions, reset values and timer figures.
// Assumes a single system clock and an 8-bit special-function-register port.
package uart_mp_pkg;

  // Special-function-register offsets.
  localparam logic [7:0] CTRL_ADDR = 8'h98;
  localparam logic [7:0] DATA_ADDR = 8'h99;

  // Control register bit positions.
  localparam int FMT_BIT  = 7;
  localparam int ONE_BIT  = 6;
  localparam int MCE_BIT  = 5;
  localparam int REN_BIT  = 4;
  localparam int TB8_BIT  = 3;
  localparam int RB8_BIT  = 2;
  localparam int TI_BIT   = 1;
  localparam int RI_BIT   = 0;

  // Reset values.
  localparam logic [7:0] CTRL_RESET = 8'h40;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Baud timer overflow value and index of the last data bit.
  localparam logic [7:0] TIMER_TOP  = 8'hFF;
  localparam logic [2:0] LAST_DATA  = 3'h7;

  // Transmit and receive sequencer states.
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} rx_state_t;

endpackage

// ### uart_mp_serial_port.sv
// Asynchronous serial port with eight/nine-bit frames and address filtering.
// Assumes a CPU special-function-register port and a timer clock enable input.
`timescale 1ns/1ps
module uart_mp_serial_port (
  // Clock and reset.
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // Special-function-register port.
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic [7:0]      sfr_rdata_o,
  // Baud timer controls.
  input  wire logic       baud_tick_i,
  input  wire logic [7:0] baud_reload_value_i,
  // Interrupt enable and request.
  input  wire logic       serial_int_enable_i,
  output logic            serial_irq_o,
  // Transmit buffer room.
  output logic            tx_buf_ready_o,
  // Serial pins.
  input  wire logic       serial_in_pin_i,
  output logic            serial_out_pin_o
);

  // Control register fields and the receive latch.
  logic                   frame_format_select_reg;
  logic                   multiproc_filter_enable_reg;
  logic                   receiver_enable_bit_reg;
  logic                   tx_ninth_bit_reg;
  logic                   rx_ninth_bit_reg;
  logic                   tx_done_flag_reg;
  logic                   rx_done_flag_reg;
  logic [7:0]             rx_latch_reg;
  // Transmit side.
  uart_mp_pkg::tx_state_t tx_state_reg;
  logic [7:0]             tx_shift_reg;
  logic [2:0]             tx_cnt_reg;
  logic                   tx_half_reg;
  logic                   tx_ninth_latch_reg;
  logic                   tx_ovf;
  logic                   tx_bit_tick;
  logic                   tx_set_done;
  logic                   buf_valid;
  logic                   buf_pop;
  logic [7:0]             buf_data;
  // Receive side.
  uart_mp_pkg::rx_state_t rx_state_reg;
  logic [7:0]             rx_shift_reg;
  logic [2:0]             rx_cnt_reg;
  logic                   rx_half_reg;
  logic                   rx_ninth_cap_reg;
  logic                   rx_prev_reg;
  logic                   rx_ovf;
  logic                   rx_sample;
  logic                   rx_start_edge;
  logic                   rx_stop_sample;
  logic                   rx_accept;
  // Register strobes.
  logic                   wr_ctrl;
  logic                   wr_data;
  logic                   rd_ctrl;

  // Register decode of the special-function-register port.
  assign wr_ctrl = sfr_wr_i && sfr_addr_i == uart_mp_pkg::CTRL_ADDR;
  assign wr_data = sfr_wr_i && sfr_addr_i == uart_mp_pkg::DATA_ADDR;
  assign rd_ctrl = sfr_rd_i && sfr_addr_i == uart_mp_pkg::CTRL_ADDR;

  // Transmit-side buffer between the data register and the shifter.
  two_entry_buffer u_tx_buf (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .in_valid_i  (wr_data),
    .in_ready_o  (tx_buf_ready_o),
    .in_data_i   (sfr_wdata_i),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_pop),
    .out_data_o  (buf_data)
  );

  // Transmit and receive baud timers share the reload value.
  baud_timer u_tx_timer (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .tick_i    (baud_tick_i),
    .reload_i  (baud_reload_value_i),
    .restart_i (1'b0),
    .ovf_o     (tx_ovf)
  );

  baud_timer u_rx_timer (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .tick_i    (baud_tick_i),
    .reload_i  (baud_reload_value_i),
    .restart_i (rx_start_edge),
    .ovf_o     (rx_ovf)
  );

  // The shifter only takes a byte when it is idle; otherwise the buffer holds it.
  assign buf_pop     = tx_state_reg == uart_mp_pkg::TX_IDLE && buf_valid;
  assign tx_bit_tick = tx_ovf && tx_half_reg;
  // Eight-bit frames are done after the last data bit, nine-bit ones after the ninth.
  assign tx_set_done = tx_bit_tick
                       && ((tx_state_reg == uart_mp_pkg::TX_DATA && !frame_format_select_reg
                            && tx_cnt_reg == uart_mp_pkg::LAST_DATA)
                           || tx_state_reg == uart_mp_pkg::TX_NINTH);

  // Halves the transmit timer overflow rate.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_half_reg <= 1'b0;
    end else begin
      tx_half_reg <= tx_half_reg ^ tx_ovf;
    end
  end

  // Transmit sequencer: start, eight data bits, optional ninth, stop.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_state_reg       <= uart_mp_pkg::TX_IDLE;
      tx_shift_reg       <= 8'h00;
      tx_cnt_reg         <= 3'h0;
      tx_ninth_latch_reg <= 1'b0;
      serial_out_pin_o   <= 1'b1;
    end else begin
      unique case (tx_state_reg)
        uart_mp_pkg::TX_IDLE: begin
          serial_out_pin_o <= 1'b1;
          if (buf_valid) begin
            tx_shift_reg       <= buf_data;
            tx_ninth_latch_reg <= tx_ninth_bit_reg;
            tx_cnt_reg         <= 3'h0;
            serial_out_pin_o   <= 1'b0;
            tx_state_reg       <= uart_mp_pkg::TX_START;
          end
        end
        uart_mp_pkg::TX_START: begin
          if (tx_bit_tick) begin
            serial_out_pin_o <= tx_shift_reg[0];
            tx_shift_reg     <= {1'b0, tx_shift_reg[7:1]};
            tx_state_reg     <= uart_mp_pkg::TX_DATA;
          end
        end
        uart_mp_pkg::TX_DATA: begin
          if (tx_bit_tick) begin
            tx_cnt_reg <= tx_cnt_reg + 3'h1;
            if (tx_cnt_reg != uart_mp_pkg::LAST_DATA) begin
              serial_out_pin_o <= tx_shift_reg[0];
              tx_shift_reg     <= {1'b0, tx_shift_reg[7:1]};
            end else if (frame_format_select_reg) begin
              serial_out_pin_o <= tx_ninth_latch_reg;
              tx_state_reg     <= uart_mp_pkg::TX_NINTH;
            end else begin
              serial_out_pin_o <= 1'b1;
              tx_state_reg     <= uart_mp_pkg::TX_STOP;
            end
          end
        end
        uart_mp_pkg::TX_NINTH: begin
          if (tx_bit_tick) begin
            serial_out_pin_o <= 1'b1;
            tx_state_reg     <= uart_mp_pkg::TX_STOP;
          end
        end
        uart_mp_pkg::TX_STOP: begin
          if (tx_bit_tick) begin
            tx_state_reg <= uart_mp_pkg::TX_IDLE;
          end
        end
      endcase
    end
  end

  // Receive sampling: first overflow after the restart falls mid start bit.
  assign rx_start_edge  = rx_state_reg == uart_mp_pkg::RX_IDLE && receiver_enable_bit_reg
                          && rx_prev_reg && !serial_in_pin_i;
  assign rx_sample      = rx_ovf && !rx_half_reg;
  assign rx_stop_sample = rx_sample && rx_state_reg == uart_mp_pkg::RX_STOP;
  // Filter checks the ninth bit in nine-bit mode and the stop bit otherwise.
  assign rx_accept      = !rx_done_flag_reg && (!multiproc_filter_enable_reg
                          || (frame_format_select_reg ? rx_ninth_cap_reg
                                                      : serial_in_pin_i));

  // Line history and the divide-by-two phase of the receive timer.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_prev_reg <= 1'b1;
      rx_half_reg <= 1'b0;
    end else begin
      rx_prev_reg <= serial_in_pin_i;
      rx_half_reg <= rx_start_edge ? 1'b0 : rx_half_reg ^ rx_ovf;
    end
  end

  // Receive sequencer.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_state_reg     <= uart_mp_pkg::RX_IDLE;
      rx_shift_reg     <= 8'h00;
      rx_cnt_reg       <= 3'h0;
      rx_ninth_cap_reg <= 1'b0;
    end else begin
      unique case (rx_state_reg)
        uart_mp_pkg::RX_IDLE: begin
          rx_cnt_reg <= 3'h0;
          if (rx_start_edge) begin
            rx_state_reg <= uart_mp_pkg::RX_START;
          end
        end
        uart_mp_pkg::RX_START: begin
          if (rx_sample) begin
            rx_state_reg <= serial_in_pin_i ? uart_mp_pkg::RX_IDLE : uart_mp_pkg::RX_DATA;
          end
        end
        uart_mp_pkg::RX_DATA: begin
          if (rx_sample) begin
            rx_shift_reg <= {serial_in_pin_i, rx_shift_reg[7:1]};
            rx_cnt_reg   <= rx_cnt_reg + 3'h1;
            if (rx_cnt_reg == uart_mp_pkg::LAST_DATA) begin
              rx_state_reg <= frame_format_select_reg ? uart_mp_pkg::RX_NINTH
                                                      : uart_mp_pkg::RX_STOP;
            end
          end
        end
        uart_mp_pkg::RX_NINTH: begin
          if (rx_sample) begin
            rx_ninth_cap_reg <= serial_in_pin_i;
            rx_state_reg     <= uart_mp_pkg::RX_STOP;
          end
        end
        uart_mp_pkg::RX_STOP: begin
          if (rx_sample) begin
            rx_state_reg <= uart_mp_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  // Receive latch loads only for an accepted byte.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_latch_reg <= uart_mp_pkg::DATA_RESET;
    end else if (rx_stop_sample && rx_accept) begin
      rx_latch_reg <= rx_shift_reg;
    end
  end

  // Control register; hardware sets of the done flags win over software clears.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_format_select_reg     <= uart_mp_pkg::CTRL_RESET[uart_mp_pkg::FMT_BIT];
      multiproc_filter_enable_reg <= uart_mp_pkg::CTRL_RESET[uart_mp_pkg::MCE_BIT];
      receiver_enable_bit_reg     <= uart_mp_pkg::CTRL_RESET[uart_mp_pkg::REN_BIT];
      tx_ninth_bit_reg            <= uart_mp_pkg::CTRL_RESET[uart_mp_pkg::TB8_BIT];
      rx_ninth_bit_reg            <= uart_mp_pkg::CTRL_RESET[uart_mp_pkg::RB8_BIT];
      tx_done_flag_reg            <= uart_mp_pkg::CTRL_RESET[uart_mp_pkg::TI_BIT];
      rx_done_flag_reg            <= uart_mp_pkg::CTRL_RESET[uart_mp_pkg::RI_BIT];
    end else begin
      if (wr_ctrl) begin
        frame_format_select_reg     <= sfr_wdata_i[uart_mp_pkg::FMT_BIT];
        multiproc_filter_enable_reg <= sfr_wdata_i[uart_mp_pkg::MCE_BIT];
        receiver_enable_bit_reg     <= sfr_wdata_i[uart_mp_pkg::REN_BIT];
        tx_ninth_bit_reg            <= sfr_wdata_i[uart_mp_pkg::TB8_BIT];
      end
      if (rx_stop_sample && rx_accept) begin
        rx_ninth_bit_reg <= frame_format_select_reg ? rx_ninth_cap_reg
                                                    : serial_in_pin_i;
      end else if (wr_ctrl) begin
        rx_ninth_bit_reg <= sfr_wdata_i[uart_mp_pkg::RB8_BIT];
      end
      if (tx_set_done) begin
        tx_done_flag_reg <= 1'b1;
      end else if (wr_ctrl) begin
        tx_done_flag_reg <= sfr_wdata_i[uart_mp_pkg::TI_BIT];
      end
      if (rx_stop_sample && rx_accept) begin
        rx_done_flag_reg <= 1'b1;
      end else if (wr_ctrl) begin
        rx_done_flag_reg <= sfr_wdata_i[uart_mp_pkg::RI_BIT];
      end
    end
  end

  // Read data and the serial interrupt request, both registered.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sfr_rdata_o  <= 8'h00;
      serial_irq_o <= 1'b0;
    end else begin
      serial_irq_o <= serial_int_enable_i
                      && (tx_done_flag_reg || rx_done_flag_reg);
      if (rd_ctrl) begin
        sfr_rdata_o <= {frame_format_select_reg, 1'b1, multiproc_filter_enable_reg,
                        receiver_enable_bit_reg, tx_ninth_bit_reg, rx_ninth_bit_reg,
                        tx_done_flag_reg, rx_done_flag_reg};
      end else if (sfr_rd_i && sfr_addr_i == uart_mp_pkg::DATA_ADDR) begin
        sfr_rdata_o <= rx_latch_reg;
      end else begin
        sfr_rdata_o <= 8'h00;
      end
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence data_write_idle_s;
    wr_data && tx_state_reg == uart_mp_pkg::TX_IDLE && !buf_valid;
  endsequence

  sequence start_bit_s;
    ##2 !serial_out_pin_o && tx_state_reg == uart_mp_pkg::TX_START;
  endsequence

  tx_write_start_a: assert property (data_write_idle_s |-> start_bit_s)
    else $error("Data write did not start a frame.");
  tx_done_set_a: assert property (tx_set_done |=> tx_done_flag_reg && serial_out_pin_o)
    else $error("Transmit done not set at stop bit.");
  tx_ninth_out_a: assert property (tx_state_reg == uart_mp_pkg::TX_NINTH
                                   |-> serial_out_pin_o == tx_ninth_latch_reg)
    else $error("Ninth bit sent with wrong level.");
  rx_done_hold_a: assert property (rx_done_flag_reg && !wr_ctrl |=> rx_done_flag_reg)
    else $error("Receive done cleared without software.");
  rx_disabled_idle_a: assert property (!receiver_enable_bit_reg
                                       && rx_state_reg == uart_mp_pkg::RX_IDLE
                                       |=> rx_state_reg == uart_mp_pkg::RX_IDLE)
    else $error("Receiver started while disabled.");
  ctrl_bit6_read_a: assert property (rd_ctrl |=> sfr_rdata_o[uart_mp_pkg::ONE_BIT])
    else $error("Unused control bit read as zero.");
  ninth_filter_a: assert property (rx_stop_sample && frame_format_select_reg
                                   && multiproc_filter_enable_reg && !rx_ninth_cap_reg
                                   && !rx_done_flag_reg
                                   |=> !rx_done_flag_reg && $stable(rx_latch_reg))
    else $error("Data byte passed the address filter.");
  stop_filter_a: assert property (rx_stop_sample && !frame_format_select_reg
                                  && multiproc_filter_enable_reg && !serial_in_pin_i
                                  |=> $stable(rx_latch_reg))
    else $error("Bad stop bit accepted.");
  rx_full_keep_a: assert property (rx_stop_sample && rx_done_flag_reg
                                   |=> $stable(rx_latch_reg) && $stable(rx_ninth_bit_reg))
    else $error("Receive latch overwritten while full.");
  rx_accept_flag_a: assert property (rx_stop_sample && rx_accept
                                     |=> rx_done_flag_reg && rx_latch_reg == $past(rx_shift_reg))
    else $error("Accepted byte not latched.");

endmodule // uart_mp_serial_port
